// >>> inc/sprc_pkg.sv
// constants, types and helper functions for the spreading rate configuration block
`default_nettype none
package sprc_pkg;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned BE_W    = DATA_W / 8;
    localparam int unsigned CODE_W  = 64;
    localparam int unsigned HALF_W  = 32;
    localparam int unsigned RATE_W  = 3;

    localparam logic [ADDR_W-1:0] OFF_RATE    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CODE_LO = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CODE_HI = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STAT    = 8'h14;

    localparam logic [RATE_W-1:0] RATE_RESET = 3'h0;
    localparam logic [CODE_W-1:0] CODE_RESET = 64'h0;
    localparam int unsigned BIT_OS   = 0;
    localparam int unsigned BIT_DDR  = 1;
    localparam int unsigned BIT_CW   = 2;
    localparam int unsigned BIT_HALF = 0;

    typedef struct packed {
        logic code32;
        logic double_rate;
        logic os12;
        logic dual_code;
        logic code_half;
    } sprc_mode_t;

    typedef enum logic [1:0] {
        SPRC_EMPTY = 2'h0,
        SPRC_ONE   = 2'h1,
        SPRC_OUT   = 2'h3
    } sprc_state_t;

    function automatic logic [HALF_W-1:0] sprc_half(input logic [CODE_W-1:0] code,
                                                    input logic upper);
        sprc_half = upper ? code[CODE_W-1:HALF_W] : code[HALF_W-1:0];
    endfunction : sprc_half

    function automatic logic [DATA_W-1:0] sprc_be_merge(input logic [DATA_W-1:0] old_v,
                                                        input logic [DATA_W-1:0] new_v,
                                                        input logic [BE_W-1:0]   be);
        logic [DATA_W-1:0] r;
        r = old_v;
        for (int i = 0; i < BE_W; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        sprc_be_merge = r;
    endfunction : sprc_be_merge

    // effective mode; rate and oversampling only count in the 32-chip cases
    function automatic sprc_mode_t sprc_decode(input logic [RATE_W-1:0] rate,
                                               input logic half);
        sprc_mode_t m;
        m.code32      = rate[BIT_CW];
        m.double_rate = rate[BIT_CW] & rate[BIT_DDR];
        m.os12        = rate[BIT_CW] & ~rate[BIT_DDR] & rate[BIT_OS];
        m.dual_code   = rate[BIT_CW] & ~rate[BIT_DDR] & ~rate[BIT_OS];
        m.code_half   = half;
        sprc_decode   = m;
    endfunction : sprc_decode
endpackage : sprc_pkg
`default_nettype wire

// >>> rtl/sprc_code_slice.sv
// registered correlator setup: chip length, oversampling and code halves
`default_nettype none
module sprc_code_slice #(
    parameter int unsigned CODE_W = sprc_pkg::CODE_W
) (
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic [CODE_W-1:0] code_i,
    input  wire sprc_pkg::sprc_mode_t mode_i,
    output logic [CODE_W-1:0]      corr_code_o,
    output logic                   corr_len32_o,
    output logic                   corr_os12_o,
    output logic                   corr_dual_o
);
    logic [CODE_W-1:0] next_code;
    logic              next_len32;
    logic              next_os12;
    logic              next_dual;

    always_comb begin
        next_len32 = mode_i.code32;
        next_os12  = mode_i.os12;
        next_dual  = mode_i.dual_code;
        next_code  = code_i;
        if (mode_i.code32) begin
            // low word is the primary code; high word is the second correlator code
            next_code = {sprc_pkg::sprc_half(code_i, ~mode_i.code_half),
                         sprc_pkg::sprc_half(code_i, mode_i.code_half)};
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            corr_code_o  <= sprc_pkg::CODE_RESET;
            corr_len32_o <= 1'b0;
            corr_os12_o  <= 1'b0;
            corr_dual_o  <= 1'b0;
        end else begin
            corr_code_o  <= next_code;
            corr_len32_o <= next_len32;
            corr_os12_o  <= next_os12;
            corr_dual_o  <= next_dual;
        end
    end
endmodule : sprc_code_slice
`default_nettype wire

// >>> rtl/sprc_top.sv
// spreading rate configuration: registers, correlator setup and bit-to-chip encoder
// Operation
// - bit 2 selects 32 or 64 chips
// - double rate packs two bits per code
// - normal rate maps one bit per code
// - rate bit only counts with 32 chips
// - double rate: each 32-chip period two bits
// - one 64-chip code split into halves
// - normal 32-chip rate: one bit per period
// - normal 32-chip rate correlates two codes unless 12x
// - bit 0 selects 12x or 6x oversampling
// - oversampling ignored for 64-chip or double
// - 12x oversampling leaves a single code
// - half select picks upper or lower chips
`default_nettype none
module sprc_top #(
    parameter int unsigned CODE_W = sprc_pkg::CODE_W
) (
    input  wire logic                        clk_i,
    input  wire logic                        rstn_i,
    input  wire logic [sprc_pkg::ADDR_W-1:0] avs_address_i,
    input  wire logic                        avs_read_i,
    input  wire logic                        avs_write_i,
    input  wire logic [sprc_pkg::DATA_W-1:0] avs_writedata_i,
    input  wire logic [sprc_pkg::BE_W-1:0]   avs_byteenable_i,
    output logic [sprc_pkg::DATA_W-1:0]      avs_readdata_o,
    output logic                             avs_waitrequest_o,
    input  wire logic                        tx_valid_i,
    input  wire logic                        tx_bit_i,
    output logic                             tx_ready_o,
    output logic                             sym_valid_o,
    input  wire logic                        sym_ready_i,
    output logic [CODE_W-1:0]                sym_chips_o,
    output logic                             sym_len32_o,
    output logic                             sym_pair_o,
    output logic [CODE_W-1:0]                corr_code_o,
    output logic                             corr_len32_o,
    output logic                             corr_os12_o,
    output logic                             corr_dual_o
);
    localparam int unsigned DW = sprc_pkg::DATA_W;
    localparam int unsigned HW = sprc_pkg::HALF_W;

    // register bus group
    logic                        ack;
    logic                        next_ack;
    logic [DW-1:0]               next_rdata;
    logic [sprc_pkg::RATE_W-1:0] rate;
    logic [sprc_pkg::RATE_W-1:0] next_rate;
    logic [CODE_W-1:0]           code;
    logic [CODE_W-1:0]           next_code;
    logic                        half;
    logic                        next_half;
    logic                        req;
    logic                        wr_go;
    sprc_pkg::sprc_mode_t        mode;

    // encoder group
    sprc_pkg::sprc_state_t state;
    sprc_pkg::sprc_state_t next_state;
    logic                  first_bit;
    logic                  next_first_bit;
    logic [CODE_W-1:0]     next_chips;
    logic                  next_len32;
    logic                  next_pair;
    logic                  accept;

    assign req               = avs_read_i | avs_write_i;
    // one wait cycle per access: the answer comes at the second edge of the request
    assign avs_waitrequest_o = req & ~ack;
    assign wr_go             = avs_write_i & ack;
    assign mode              = sprc_pkg::sprc_decode(rate, half);

    always_comb begin
        next_ack   = req & ~ack;
        next_rdata = avs_readdata_o;
        next_rate  = rate;
        next_code  = code;
        next_half  = half;
        if (avs_read_i && !ack) begin
            case (avs_address_i)
                sprc_pkg::OFF_RATE:    next_rdata = DW'(rate);
                sprc_pkg::OFF_CODE_LO: next_rdata = code[HW-1:0];
                sprc_pkg::OFF_CODE_HI: next_rdata = code[CODE_W-1:HW];
                sprc_pkg::OFF_CTRL:    next_rdata = DW'(half);
                sprc_pkg::OFF_STAT:    next_rdata = DW'({state, mode});
                default:               next_rdata = '0;
            endcase
        end
        if (wr_go) begin
            case (avs_address_i)
                sprc_pkg::OFF_RATE: begin
                    // reserved bits are not stored and read back as zero
                    if (avs_byteenable_i[0]) begin
                        next_rate = avs_writedata_i[sprc_pkg::RATE_W-1:0];
                    end
                end
                sprc_pkg::OFF_CODE_LO: begin
                    next_code[HW-1:0] = sprc_pkg::sprc_be_merge(code[HW-1:0],
                                                                avs_writedata_i,
                                                                avs_byteenable_i);
                end
                sprc_pkg::OFF_CODE_HI: begin
                    next_code[CODE_W-1:HW] = sprc_pkg::sprc_be_merge(code[CODE_W-1:HW],
                                                                     avs_writedata_i,
                                                                     avs_byteenable_i);
                end
                sprc_pkg::OFF_CTRL: begin
                    if (avs_byteenable_i[0]) begin
                        next_half = avs_writedata_i[sprc_pkg::BIT_HALF];
                    end
                end
                default: begin
                    next_half = half;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack            <= 1'b0;
            avs_readdata_o <= '0;
            rate           <= sprc_pkg::RATE_RESET;
            code           <= sprc_pkg::CODE_RESET;
            half           <= 1'b0;
        end else begin
            ack            <= next_ack;
            avs_readdata_o <= next_rdata;
            rate           <= next_rate;
            code           <= next_code;
            half           <= next_half;
        end
    end

    sprc_code_slice #(
        .CODE_W (CODE_W)
    ) u_slice (
        .clk_i        (clk_i),
        .rstn_i       (rstn_i),
        .code_i       (code),
        .mode_i       (mode),
        .corr_code_o  (corr_code_o),
        .corr_len32_o (corr_len32_o),
        .corr_os12_o  (corr_os12_o),
        .corr_dual_o  (corr_dual_o)
    );

    // encoder: a bit of 1 sends the code, a bit of 0 sends it inverted, except the first bit of a double-rate pair, which picks the half
    assign tx_ready_o  = (state != sprc_pkg::SPRC_OUT);
    assign sym_valid_o = (state == sprc_pkg::SPRC_OUT);
    assign accept      = tx_valid_i & tx_ready_o;

    always_comb begin
        next_state     = state;
        next_first_bit = first_bit;
        next_chips     = sym_chips_o;
        next_len32     = sym_len32_o;
        next_pair      = sym_pair_o;
        case (state)
            sprc_pkg::SPRC_EMPTY: begin
                if (accept && mode.double_rate) begin
                    next_first_bit = tx_bit_i;
                    next_state     = sprc_pkg::SPRC_ONE;
                end else if (accept && mode.code32) begin
                    next_chips = CODE_W'(sprc_pkg::sprc_half(code, mode.code_half)
                                         ^ {HW{~tx_bit_i}});
                    next_len32 = 1'b1;
                    next_pair  = 1'b0;
                    next_state = sprc_pkg::SPRC_OUT;
                end else if (accept) begin
                    next_chips = code ^ {CODE_W{~tx_bit_i}};
                    next_len32 = 1'b0;
                    next_pair  = 1'b0;
                    next_state = sprc_pkg::SPRC_OUT;
                end
            end
            sprc_pkg::SPRC_ONE: begin
                // an odd bit waits here for its partner: no odd-length frames
                if (accept) begin
                    next_chips = CODE_W'(sprc_pkg::sprc_half(code, first_bit)
                                         ^ {HW{~tx_bit_i}});
                    next_len32 = 1'b1;
                    next_pair  = 1'b1;
                    next_state = sprc_pkg::SPRC_OUT;
                end
            end
            sprc_pkg::SPRC_OUT: begin
                if (sym_ready_i) begin
                    next_state = sprc_pkg::SPRC_EMPTY;
                end
            end
            default: begin
                next_state = sprc_pkg::SPRC_EMPTY;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state       <= sprc_pkg::SPRC_EMPTY;
            first_bit   <= 1'b0;
            sym_chips_o <= '0;
            sym_len32_o <= 1'b0;
            sym_pair_o  <= 1'b0;
        end else begin
            state       <= next_state;
            first_bit   <= next_first_bit;
            sym_chips_o <= next_chips;
            sym_len32_o <= next_len32;
            sym_pair_o  <= next_pair;
        end
    end

    // checks
    sequence s_first_of_pair;
        state == sprc_pkg::SPRC_EMPTY && accept && mode.double_rate;
    endsequence

    sequence s_second_of_pair;
        state == sprc_pkg::SPRC_ONE && accept;
    endsequence

    property p_len_sel;
        @(posedge clk_i) disable iff (!rstn_i)
        corr_len32_o == $past(rate[sprc_pkg::BIT_CW]);
    endproperty
    a_len_sel: assert property (p_len_sel) else $error("chip length mismatch");

    property p_pair_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        s_first_of_pair |=> state == sprc_pkg::SPRC_ONE && !sym_valid_o;
    endproperty
    a_pair_hold: assert property (p_pair_hold) else $error("first bit sent alone");

    property p_single;
        @(posedge clk_i) disable iff (!rstn_i)
        state == sprc_pkg::SPRC_EMPTY && accept && !mode.double_rate
        |=> sym_valid_o && !sym_pair_o;
    endproperty
    a_single: assert property (p_single) else $error("normal bit not one symbol");

    property p_ddr_32;
        @(posedge clk_i) disable iff (!rstn_i)
        sym_valid_o && sym_pair_o |-> sym_len32_o;
    endproperty
    a_ddr_32: assert property (p_ddr_32) else $error("pair symbol not 32 chips");

    property p_pair_sym;
        @(posedge clk_i) disable iff (!rstn_i)
        s_first_of_pair ##1 s_second_of_pair |=> sym_valid_o && sym_pair_o;
    endproperty
    a_pair_sym: assert property (p_pair_sym) else $error("pair not one symbol");

    property p_half_chips;
        @(posedge clk_i) disable iff (!rstn_i)
        s_second_of_pair |=> sym_chips_o[HW-1:0] ==
            (sprc_pkg::sprc_half($past(code), $past(first_bit)) ^ {HW{~$past(tx_bit_i)}});
    endproperty
    a_half_chips: assert property (p_half_chips) else $error("pair chips wrong");

    property p_n32;
        @(posedge clk_i) disable iff (!rstn_i)
        state == sprc_pkg::SPRC_EMPTY && accept && mode.code32 && !mode.double_rate
        |=> sym_len32_o && !sym_pair_o;
    endproperty
    a_n32: assert property (p_n32) else $error("normal 32-chip symbol wrong");

    property p_dual;
        @(posedge clk_i) disable iff (!rstn_i)
        corr_dual_o == $past(rate == {1'b1, 1'b0, 1'b0});
    endproperty
    a_dual: assert property (p_dual) else $error("dual code setup wrong");

    property p_os;
        @(posedge clk_i) disable iff (!rstn_i)
        corr_os12_o == $past(rate == {1'b1, 1'b0, 1'b1});
    endproperty
    a_os: assert property (p_os) else $error("oversampling setup wrong");

    property p_os_single;
        @(posedge clk_i) disable iff (!rstn_i)
        corr_os12_o |-> !corr_dual_o && corr_len32_o;
    endproperty
    a_os_single: assert property (p_os_single) else $error("12x with two codes");

    property p_code_half;
        @(posedge clk_i) disable iff (!rstn_i)
        $past(rate[sprc_pkg::BIT_CW]) |->
            corr_code_o[HW-1:0] == sprc_pkg::sprc_half($past(code), $past(half));
    endproperty
    a_code_half: assert property (p_code_half) else $error("code half wrong");

    property p_bus;
        @(posedge clk_i) disable iff (!rstn_i)
        avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer late");

    property p_rate_read;
        @(posedge clk_i) disable iff (!rstn_i)
        avs_read_i && !ack && avs_address_i == sprc_pkg::OFF_RATE
        |=> avs_readdata_o == DW'($past(rate));
    endproperty
    a_rate_read: assert property (p_rate_read) else $error("rate readback wrong");
endmodule : sprc_top
`default_nettype wire

// >>> bench/sprc_host_model.sv
// host model: avalon master that programs the rate, code and half select registers
`default_nettype none
module sprc_host_model (
    input  wire logic [0:0]  clk_i,
    output logic [7:0]       avs_address_o,
    output logic             avs_read_o,
    output logic             avs_write_o,
    output logic [31:0]      avs_writedata_o,
    output logic [3:0]       avs_byteenable_o,
    input  wire logic [31:0] avs_readdata_i,
    input  wire logic        avs_waitrequest_i
);
    timeunit 1ns;
    timeprecision 1ps;
    int hangs = 0;
    initial begin
        avs_address_o    = 8'h00;
        avs_read_o       = 1'b0;
        avs_write_o      = 1'b0;
        avs_writedata_o  = 32'h0;
        avs_byteenable_o = 4'hF;
    end
    // request held until waitrequest is seen low at an edge; data taken at that edge
    task automatic access(input logic wr, input logic [7:0] addr,
                          input logic [31:0] wdata, output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_o   <= addr;
        avs_writedata_o <= wdata;
        avs_write_o     <= wr;
        avs_read_o      <= ~wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_i !== 1'b0 && n < 50);
        if (n >= 50) begin
            hangs++;
        end
        rdata = avs_readdata_i;
        avs_write_o <= 1'b0;
        avs_read_o  <= 1'b0;
    endtask : access
    // rate and half select always go together, since both hang on the chip length
    task automatic rate_write(input logic [2:0] rate, input logic half);
        logic [31:0] d;
        logic [2:0]  r;
        r = (rate == 3'h1 || rate == 3'h2) ? 3'h0 : rate;
        access(1'b1, sprc_pkg::OFF_RATE, {29'h0, r}, d);
        access(1'b1, sprc_pkg::OFF_CTRL, {31'h0, half}, d);
    endtask : rate_write
    task automatic code_write(input logic [63:0] code);
        logic [31:0] d;
        access(1'b1, sprc_pkg::OFF_CODE_LO, code[31:0], d);
        access(1'b1, sprc_pkg::OFF_CODE_HI, code[63:32], d);
    endtask : code_write
endmodule : sprc_host_model
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the spreading rate configuration block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] rate;
        logic       half;
        logic       len32;
        logic       os12;
        logic       dual;
    } sprc_row_t;
    localparam logic [63:0] CODE = 64'hF0E1D2C3_5A6B7C8D;
    logic        clk_i;
    logic        rstn_i;
    logic [7:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        tx_valid_i;
    logic        tx_bit_i;
    logic        tx_ready_o;
    logic        sym_valid_o;
    logic        sym_ready_i;
    logic [63:0] sym_chips_o;
    logic        sym_len32_o;
    logic        sym_pair_o;
    logic [63:0] corr_code_o;
    logic        corr_len32_o;
    logic        corr_os12_o;
    logic        corr_dual_o;
    int          fail_count = 0;
    int          tests_run = 0;
    logic [31:0] rv;
    logic [31:0] st;
    logic [31:0] sel;
    logic [31:0] oth;
    // rate, half, then expected correlator length, 12x and two-code flags
    sprc_row_t   rows [6] = '{
        '{3'h0, 1'b0, 1'b0, 1'b0, 1'b0},
        '{3'h4, 1'b0, 1'b1, 1'b0, 1'b1},
        '{3'h4, 1'b1, 1'b1, 1'b0, 1'b1},
        '{3'h5, 1'b0, 1'b1, 1'b1, 1'b0},
        '{3'h6, 1'b1, 1'b1, 1'b0, 1'b0},
        '{3'h7, 1'b0, 1'b1, 1'b0, 1'b0}};

    sprc_host_model i_host (
        .clk_i             (clk_i),
        .avs_address_o     (avs_address_i),
        .avs_read_o        (avs_read_i),
        .avs_write_o       (avs_write_i),
        .avs_writedata_o   (avs_writedata_i),
        .avs_byteenable_o  (avs_byteenable_i),
        .avs_readdata_i    (avs_readdata_o),
        .avs_waitrequest_i (avs_waitrequest_o)
    );
    sprc_top i_dut (
        .clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .tx_valid_i, .tx_bit_i,
        .tx_ready_o, .sym_valid_o, .sym_ready_i, .sym_chips_o, .sym_len32_o, .sym_pair_o,
        .corr_code_o, .corr_len32_o, .corr_os12_o, .corr_dual_o
    );

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic send_bit(input logic b);
        int n;
        n = 0;
        @(posedge clk_i);
        tx_valid_i <= 1'b1;
        tx_bit_i   <= b;
        do begin
            @(posedge clk_i);
            n++;
        end while (tx_ready_o !== 1'b1 && n < 50);
        tx_valid_i <= 1'b0;
        if (n >= 50) begin
            fail_count++;
        end
    endtask : send_bit

    // both bits of a pair back to back, valid held high between them
    task automatic send_pair(input logic a, input logic b);
        int n;
        n = 0;
        @(posedge clk_i);
        tx_valid_i <= 1'b1;
        tx_bit_i   <= a;
        repeat (2) begin
            do begin
                @(posedge clk_i);
                n++;
            end while (tx_ready_o !== 1'b1 && n < 50);
            tx_bit_i <= b;
        end
        tx_valid_i <= 1'b0;
        if (n >= 50) begin
            fail_count++;
        end
    endtask : send_pair

    task automatic take_sym(input logic [63:0] chips, input logic pair, input logic len32);
        int n;
        n = 0;
        @(posedge clk_i);
        sym_ready_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (sym_valid_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
        end
        check(sym_chips_o, chips, "symbol chips");
        check({sym_pair_o, sym_len32_o}, {pair, len32}, "symbol kind");
        sym_ready_i <= 1'b0;
    endtask : take_sym

    task automatic final_report();
        fail_count += i_host.hangs;
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (6000) @(posedge clk_i);
        fail_count++;
        final_report();
    end

    initial begin
        rstn_i      = 1'b0;
        tx_valid_i  = 1'b0;
        tx_bit_i    = 1'b0;
        sym_ready_i = 1'b0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        i_host.access(1'b0, sprc_pkg::OFF_RATE, 32'h0, rv);
        check(rv, 32'h0, "rate after reset");
        check({corr_len32_o, corr_os12_o, corr_dual_o}, 3'h0, "mode after reset");
        i_host.code_write(CODE);
        foreach (rows[i]) begin
            i_host.rate_write(rows[i].rate, rows[i].half);
            repeat (2) @(posedge clk_i);
            #1;
            sel = rows[i].half ? CODE[63:32] : CODE[31:0];
            oth = rows[i].half ? CODE[31:0] : CODE[63:32];
            st  = {27'h0, rows[i].len32, &rows[i].rate[2:1], rows[i].os12, rows[i].dual,
                   rows[i].half};
            check({corr_len32_o, corr_os12_o, corr_dual_o},
                  {rows[i].len32, rows[i].os12, rows[i].dual}, "mode");
            check(corr_code_o, rows[i].len32 ? {oth, sel} : CODE, "code");
            i_host.access(1'b0, sprc_pkg::OFF_STAT, 32'h0, rv);
            check(rv, st, "status");
            if (&rows[i].rate[2:1]) begin
                send_pair(1'b1, 1'b0);
                take_sym({32'h0, ~CODE[63:32]}, 1'b1, 1'b1);
            end else begin
                send_bit(1'b1);
                take_sym(rows[i].len32 ? {32'h0, sel} : CODE, 1'b0, rows[i].len32);
            end
        end
        // a careless host setting reserved bits must not leave them stored
        i_host.access(1'b1, sprc_pkg::OFF_RATE, 32'hFF, rv);
        i_host.access(1'b0, sprc_pkg::OFF_RATE, 32'h0, rv);
        check(rv, 32'h7, "reserved bits");
        i_host.access(1'b0, 8'h3C, 32'h0, rv);
        check(rv, 32'h0, "unmapped read");
        // a lone bit in double rate never becomes a symbol of its own
        i_host.rate_write(3'h6, 1'b0);
        send_bit(1'b0);
        repeat (5) @(posedge clk_i);
        check(sym_valid_o, 1'b0, "odd bit");
        send_bit(1'b1);
        take_sym({32'h0, CODE[31:0]}, 1'b1, 1'b1);
        // downstream stalls: no new bit is taken while the symbol waits
        i_host.rate_write(3'h4, 1'b1);
        send_bit(1'b0);
        repeat (3) @(posedge clk_i);
        check(tx_ready_o, 1'b0, "ready while symbol waits");
        take_sym({32'h0, ~CODE[63:32]}, 1'b0, 1'b1);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1;
        check(corr_len32_o, 1'b0, "mode after second reset");
        i_host.access(1'b0, sprc_pkg::OFF_RATE, 32'h0, rv);
        check(rv, 32'h0, "rate after second reset");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
